/* rtl/cgm_pkg.sv */
// ============================================================
// shared constants and types of the clock generator mode control
package cgm_pkg;

  // ============================================================
  // output source select / status encodings
  localparam logic [1:0] OUTPUT_SOURCE_SELECT_LOOP = 2'h0;  // loop output drives the generated clock
  localparam logic [1:0] OUTPUT_SOURCE_SELECT_INT  = 2'h1;  // raw internal reference
  localparam logic [1:0] OUTPUT_SOURCE_SELECT_EXT  = 2'h2;  // raw external reference
  localparam logic [1:0] OUTPUT_SOURCE_SELECT_SYN  = 2'h3;  // status only: phase-locked loop output

  // ============================================================
  // values after reset
  localparam logic [1:0] OUTPUT_DIVIDER_RESET  = 2'h1;  // divide-by-2
  localparam logic [2:0] REFERENCE_DIVIDER_RESET  = 3'h0;
  localparam logic [3:0] SYNTH_MULTIPLIER_RESET  = 4'h1;
  localparam logic       REF_SOURCE_SELECT_RESET = 1'h1;

  // ============================================================
  // timing: reference clock rate and settle / lock times
  localparam int CLK_MHZ           = 100;
  localparam int T_IREFST_US       = 6;                       // internal reference settle time
  localparam int IREFST_CYCLES     = T_IREFST_US * CLK_MHZ;   // least time, already whole cycles
  localparam int T_LOOP_LOCK_MS    = 1;                       // loop lock time
  localparam int LOOP_LOCK_CYCLES  = T_LOOP_LOCK_MS * 1000 * CLK_MHZ;

  // ============================================================
  // frequency arithmetic
  localparam int FLL_MULT_SHIFT = 10;  // times 1024
  localparam int BUS_DIV_SHIFT  = 1;   // bus = output / 2
  localparam int SYNTH_MULTIPLIER_SHIFT     = 2;   // multiplier = 4 * code

  // ============================================================
  // operating modes, gray along fei-fbe-pbe-pee
  typedef enum logic [2:0] {
    CGM_FEI  = 3'h0,
    CGM_FBE  = 3'h1,
    CGM_PBE  = 3'h3,
    CGM_PEE  = 3'h2,
    CGM_LOWPOWER_BYPASS_EXTERNAL_MODE = 3'h6,
    CGM_LOWPOWER_BYPASS_INTERNAL_MODE = 3'h7,
    CGM_FBI  = 3'h5,
    CGM_FEE  = 3'h4
  } cgm_mode_type;

  // software control bits
  typedef struct packed {
    logic [1:0] output_source_select;
    logic [2:0] reference_divider;
    logic       ref_source_select;
    logic       internal_ref_out_enable;
    logic [1:0] output_divider;
    logic       low_power_bit;
    logic       oscillator_request;
    logic       external_ref_out_enable;
    logic       loop_type_select;
    logic [3:0] synth_multiplier;
  } cgm_cfg_type;

  // status seen by software
  typedef struct packed {
    logic [1:0] output_source_status;
    logic       ref_source_status;
    logic       loop_type_status;
    logic       lock;
    logic       oscillator_ready;
    logic       internal_ref_stable;
  } cgm_status_type;

endpackage : cgm_pkg

/* rtl/cgm_mode_ctrl.sv */
`timescale 1ns/100ps
// Functional notes
// - reset enters engaged-internal mode, divider by two
// - internal reference settles first, then a loop on it locks
// - from reset only three modes are directly reachable
// - bypassed-external keeps loop running and locking
// - external on output reports status 10
// - internal on output reports status 01
// - each selection has a matching status indication
// - bus frequency is output frequency over two
// - fll engaged output is reference times 1024
// - pll engaged output uses multiplier and dividers
// - bypassed output is raw reference over divider
// - unavailable source keeps previous clock selected
// - low-power bit stops loops in bypass, clearing lets lock
module cgm_mode_ctrl
  import cgm_pkg::*;
#(
  parameter int LOCK_CYCLES = LOOP_LOCK_CYCLES  // shorten for simulation
) (
  // clock and reset
  input  wire logic           i_ref_clk,
  input  wire logic           i_rst,
  // software control
  input  wire logic           i_cfg_write,
  input  wire cgm_cfg_type    i_cfg,
  // oscillator pin and reference frequencies
  input  wire logic           i_osc_stable,
  input  wire logic [31:0]    i_int_ref_hz,
  input  wire logic [31:0]    i_ext_ref_hz,
  // status and derived values
  output cgm_status_type      o_status,
  output cgm_mode_type        o_mode,
  output cgm_cfg_type         o_cfg,
  output logic                o_loop_enable,
  output logic                o_int_ref_enable,
  output logic                o_ext_ref_enable,
  output logic [47:0]         o_out_hz,
  output logic [47:0]         o_bus_hz
);

  // ============================================================
  // state of the block
  typedef struct packed {
    cgm_mode_type   mode;
    cgm_cfg_type    cfg;
    cgm_status_type st;
    logic           osc_meta;      // first synchroniser stage, read only by osc_sync
    logic           osc_sync;
    logic [15:0]    irc_cnt;       // internal reference settle counter
    logic [31:0]    lock_cnt;      // loop lock counter
    logic [47:0]    out_hz;
    logic [47:0]    bus_hz;
  } cgm_state_type;

  cgm_state_type s_q;             // registered state
  cgm_state_type s_d;             // next state

  // ============================================================
  // decode a control word into the mode it asks for
  function automatic cgm_mode_type decode_mode(input cgm_cfg_type c, input cgm_mode_type cur);
    cgm_mode_type m;
    m = cur;
    case (c.output_source_select)
      OUTPUT_SOURCE_SELECT_LOOP: begin
        // internal reference with pll is not a mode; treat as fei
        if (c.ref_source_select) begin
          m = CGM_FEI;
        end else begin
          m = c.loop_type_select ? CGM_PEE : CGM_FEE;
        end
      end
      OUTPUT_SOURCE_SELECT_INT: begin
        m = c.low_power_bit ? CGM_LOWPOWER_BYPASS_INTERNAL_MODE : CGM_FBI;
      end
      OUTPUT_SOURCE_SELECT_EXT: begin
        if (c.low_power_bit) begin
          m = CGM_LOWPOWER_BYPASS_EXTERNAL_MODE;
        end else begin
          m = c.loop_type_select ? CGM_PBE : CGM_FBE;
        end
      end
      default: begin
        m = cur;  // reserved select keeps the current mode
      end
    endcase
    return m;
  endfunction : decode_mode

  // ============================================================
  // next-state logic
  always_comb begin
    cgm_mode_type req_mode;
    logic         accept;
    logic         ext_avail;
    logic         int_avail;
    logic         loops_on;
    logic         ref_ok;
    logic [1:0]   want_st;
    logic [47:0]  ref_ext_hz;
    logic [47:0]  ref_hz;
    logic [47:0]  raw_hz;
    req_mode   = CGM_FEI;
    accept     = 1'b0;
    ext_avail  = 1'b0;
    int_avail  = 1'b0;
    loops_on   = 1'b0;
    ref_ok     = 1'b0;
    want_st    = OUTPUT_SOURCE_SELECT_LOOP;
    ref_ext_hz = '0;
    ref_hz     = '0;
    raw_hz     = '0;
    s_d        = s_q;

    // oscillator pin passes two flip-flops
    s_d.osc_meta = i_osc_stable;
    s_d.osc_sync = s_q.osc_meta;
    // ready only while a crystal is requested
    s_d.st.oscillator_ready = s_q.osc_sync & s_q.cfg.oscillator_request;

    // software writes are taken only toward a reachable mode
    if (i_cfg_write) begin
      req_mode = decode_mode(i_cfg, s_q.mode);
      // from reset mode only fee, fbe and fbi are entered directly
      accept = (s_q.mode != CGM_FEI) || (req_mode == CGM_FEI) || (req_mode == CGM_FEE) ||
               (req_mode == CGM_FBE) || (req_mode == CGM_FBI);
      if (i_cfg.output_source_select == OUTPUT_SOURCE_SELECT_SYN) begin
        accept = 1'b0;  // reserved encoding ignored
      end
      if (accept) begin
        s_d.cfg  = i_cfg;  // output divider takes effect at once
        s_d.mode = req_mode;
      end
    end

    // internal reference settles before a loop on it may lock
    if (s_q.irc_cnt < 16'(IREFST_CYCLES)) begin
      s_d.irc_cnt = s_q.irc_cnt + 16'h0001;
    end
    s_d.st.internal_ref_stable = (s_q.irc_cnt >= 16'(IREFST_CYCLES));

    // source availability: a crystal must report ready
    int_avail = s_q.st.internal_ref_stable;
    ext_avail = s_q.cfg.oscillator_request ? s_q.st.oscillator_ready : 1'b1;

    // reference source status follows the select once available
    if (s_q.cfg.ref_source_select ? int_avail : ext_avail) begin
      s_d.st.ref_source_status = s_q.cfg.ref_source_select;
    end
    s_d.st.loop_type_status = s_q.cfg.loop_type_select;

    // loops run unless low power and bypassed; bypassed-external keeps locking
    loops_on = !(s_q.cfg.low_power_bit && (s_q.cfg.output_source_select != OUTPUT_SOURCE_SELECT_LOOP));
    ref_ok   = s_q.st.ref_source_status ? s_q.st.internal_ref_stable : ext_avail;

    // lock restarts whenever the reference or loop type changes
    if (!loops_on || !ref_ok ||
        (s_d.st.ref_source_status != s_q.st.ref_source_status) ||
        (s_d.st.loop_type_status != s_q.st.loop_type_status)) begin
      s_d.lock_cnt = '0;
      s_d.st.lock  = 1'b0;
    end else if (s_q.lock_cnt < 32'(LOCK_CYCLES)) begin
      s_d.lock_cnt = s_q.lock_cnt + 32'h0000_0001;
    end else begin
      s_d.st.lock = 1'b1;
    end

    // output source switch; unavailable target keeps the previous clock
    case (s_q.cfg.output_source_select)
      OUTPUT_SOURCE_SELECT_INT: begin
        if (int_avail) begin
          s_d.st.output_source_status = OUTPUT_SOURCE_SELECT_INT;
        end
      end
      OUTPUT_SOURCE_SELECT_EXT: begin
        if (ext_avail) begin
          s_d.st.output_source_status = OUTPUT_SOURCE_SELECT_EXT;
        end
      end
      OUTPUT_SOURCE_SELECT_LOOP: begin
        if (s_q.st.lock) begin
          want_st = s_q.st.loop_type_status ? OUTPUT_SOURCE_SELECT_SYN : OUTPUT_SOURCE_SELECT_LOOP;
          s_d.st.output_source_status = want_st;
        end
      end
      default: begin
        s_d.st.output_source_status = s_q.st.output_source_status;
      end
    endcase

    // generated clock frequency from the actual selection
    ref_ext_hz = {16'h0000, i_ext_ref_hz} >> s_q.cfg.reference_divider;
    ref_hz     = s_q.st.ref_source_status ? {16'h0000, i_int_ref_hz} : ref_ext_hz;
    case (s_q.st.output_source_status)
      OUTPUT_SOURCE_SELECT_LOOP: begin
        raw_hz = ref_hz << FLL_MULT_SHIFT;
      end
      OUTPUT_SOURCE_SELECT_SYN: begin
        raw_hz = 48'(ref_ext_hz * {s_q.cfg.synth_multiplier, 2'h0});
      end
      OUTPUT_SOURCE_SELECT_INT: begin
        raw_hz = {16'h0000, i_int_ref_hz};
      end
      default: begin
        raw_hz = {16'h0000, i_ext_ref_hz};
      end
    endcase
    s_d.out_hz = raw_hz >> s_q.cfg.output_divider;
    s_d.bus_hz = s_d.out_hz >> BUS_DIV_SHIFT;
  end

  // ============================================================
  // state register with synchronous reset
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_q                             <= '0;
      s_q.mode                        <= CGM_FEI;
      s_q.cfg.output_source_select    <= OUTPUT_SOURCE_SELECT_LOOP;
      s_q.cfg.ref_source_select       <= REF_SOURCE_SELECT_RESET;
      s_q.cfg.reference_divider       <= REFERENCE_DIVIDER_RESET;
      s_q.cfg.output_divider          <= OUTPUT_DIVIDER_RESET;
      s_q.cfg.synth_multiplier        <= SYNTH_MULTIPLIER_RESET;
      s_q.st.ref_source_status        <= REF_SOURCE_SELECT_RESET;
      s_q.st.output_source_status     <= OUTPUT_SOURCE_SELECT_LOOP;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // outputs from flip-flops; enable flags decoded from the registered control
  assign o_status         = s_q.st;
  assign o_mode           = s_q.mode;
  assign o_cfg            = s_q.cfg;
  assign o_out_hz         = s_q.out_hz;
  assign o_bus_hz         = s_q.bus_hz;
  // loops enabled flag mirrors the low-power decision
  assign o_loop_enable    = !(s_q.cfg.low_power_bit && (s_q.cfg.output_source_select != OUTPUT_SOURCE_SELECT_LOOP));
  // internal reference kept on when requested or in use
  assign o_int_ref_enable = s_q.cfg.internal_ref_out_enable | s_q.cfg.ref_source_select |
                            (s_q.cfg.output_source_select == OUTPUT_SOURCE_SELECT_INT);
  // oscillator kept on when its output or an external mode needs it
  assign o_ext_ref_enable = s_q.cfg.external_ref_out_enable | !s_q.cfg.ref_source_select |
                            (s_q.cfg.output_source_select == OUTPUT_SOURCE_SELECT_EXT);

endmodule : cgm_mode_ctrl

/* verification/cgm_monitor.sv */
`timescale 1ns/100ps
// ============================================================
// port-level checks of the mode control
module cgm_monitor
  import cgm_pkg::*;
(
  input wire logic           i_ref_clk,
  input wire logic           i_rst,
  input wire logic [31:0]    i_int_ref_hz,
  input wire logic [31:0]    i_ext_ref_hz,
  input wire cgm_status_type o_status,
  input wire cgm_mode_type   o_mode,
  input wire cgm_cfg_type    o_cfg,
  input wire logic           o_loop_enable,
  input wire logic [47:0]    o_out_hz,
  input wire logic [47:0]    o_bus_hz
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // external source picked and its crystal, if any, is ready
  sequence s_ext_held;
    ($stable(o_cfg) && o_cfg.output_source_select == OUTPUT_SOURCE_SELECT_EXT
      && (!o_cfg.oscillator_request || o_status.oscillator_ready))[*3];
  endsequence
  // internal source picked after it has settled
  sequence s_int_held;
    ($stable(o_cfg) && o_cfg.output_source_select == OUTPUT_SOURCE_SELECT_INT && o_status.internal_ref_stable)[*3];
  endsequence
  a_reset_mode: assert property (disable iff (1'h0) i_rst |=> o_mode == CGM_FEI
    && o_cfg.output_divider == OUTPUT_DIVIDER_RESET) else $error("reset mode wrong");
  a_bus_half: assert property (o_bus_hz == (o_out_hz >> 1)) else $error("bus not half");
  a_reset_exit: assert property ($past(o_mode) == CGM_FEI && o_mode != CGM_FEI
    |-> o_mode inside {CGM_FEE, CGM_FBE, CGM_FBI}) else $error("illegal exit from reset mode");
  a_lock_after_settle: assert property (o_mode == CGM_FEI && o_status.lock
    |-> o_status.internal_ref_stable) else $error("lock before settle");
  a_ext_status: assert property (s_ext_held |-> o_status.output_source_status == OUTPUT_SOURCE_SELECT_EXT)
    else $error("external status missing");
  a_int_status: assert property (s_int_held |-> o_status.output_source_status == OUTPUT_SOURCE_SELECT_INT)
    else $error("internal status missing");
  a_ref_status: assert property (($stable(o_cfg) && (o_cfg.ref_source_select
    || !o_cfg.oscillator_request || o_status.oscillator_ready))[*3]
    |-> o_status.ref_source_status == o_cfg.ref_source_select) else $error("reference status wrong");
  a_source_hold: assert property ((o_cfg.oscillator_request && !o_status.oscillator_ready
    && o_cfg.output_source_select == OUTPUT_SOURCE_SELECT_EXT)[*2] |-> $stable(o_status.output_source_status))
    else $error("unready source taken");
  a_fll_out: assert property ((o_mode == CGM_FEI && o_status.lock && $stable(o_cfg))[*4]
    |-> o_out_hz == (({16'h0, i_int_ref_hz} << FLL_MULT_SHIFT) >> o_cfg.output_divider))
    else $error("engaged frequency wrong");
  a_bypass_out: assert property ((o_mode == CGM_FBE && o_status.output_source_status == OUTPUT_SOURCE_SELECT_EXT)[*2]
    |-> o_out_hz == ({16'h0, i_ext_ref_hz} >> o_cfg.output_divider)) else $error("bypass frequency wrong");
  a_lowpower_off: assert property ((o_mode inside {CGM_LOWPOWER_BYPASS_EXTERNAL_MODE, CGM_LOWPOWER_BYPASS_INTERNAL_MODE})[*2] |-> !o_loop_enable)
    else $error("loops run in low power");
  a_bypass_runs: assert property ((o_mode == CGM_FBE)[*2] |-> o_loop_enable)
    else $error("loop stopped in bypass");
endmodule : cgm_monitor

bind cgm_mode_ctrl cgm_monitor mon (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_int_ref_hz(i_int_ref_hz),
  .i_ext_ref_hz(i_ext_ref_hz), .o_status(o_status), .o_mode(o_mode), .o_cfg(o_cfg),
  .o_loop_enable(o_loop_enable), .o_out_hz(o_out_hz), .o_bus_hz(o_bus_hz));

/* verification/cgm_osc_model.sv */
`timescale 1ns/100ps
// ============================================================
// external crystal: steady only after a run of enabled cycles
module cgm_osc_model #(
  parameter int START_CYCLES = 30  // startup, kept short for simulation
) (
  input  wire logic i_ref_clk,
  input  wire logic i_enable,
  output logic      o_stable
);
  int count_q = 0;  // cycles since enable, saturating
  // a disabled crystal loses its swing at once, so ready drops with it
  always @(posedge i_ref_clk) begin
    if (i_enable !== 1'h1) begin
      count_q <= 0;
    end else if (count_q < START_CYCLES) begin
      count_q <= count_q + 1;
    end
  end
  assign o_stable = (i_enable === 1'h1) && (count_q == START_CYCLES);
endmodule : cgm_osc_model

/* verification/cgm_mode_ctrl_tb.sv */
`timescale 1ns/100ps
// ============================================================
// directed walk through the modes
module cgm_mode_ctrl_tb;
  import cgm_pkg::*;
  localparam logic [31:0] INT_HZ = 32'h0000_8000;  // internal reference as software trimmed it
  localparam logic [31:0] EXT_HZ = 32'h003D_0900;  // 4 MHz crystal
  logic           i_ref_clk;
  logic           i_rst;
  logic           i_cfg_write;
  cgm_cfg_type    i_cfg;
  logic           i_osc_stable;
  cgm_status_type o_status;
  cgm_mode_type   o_mode;
  cgm_cfg_type    o_cfg;
  logic           o_loop_enable;
  logic           o_int_ref_enable;
  logic           o_ext_ref_enable;
  logic [47:0]    o_out_hz;
  logic [47:0]    o_bus_hz;
  cgm_cfg_type    bad[3];  // words the reset mode must refuse
  int             failures;
  int             samples_checked;
  cgm_mode_ctrl #(.LOCK_CYCLES(20)) uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cfg_write(i_cfg_write),
    .i_cfg(i_cfg), .i_osc_stable(i_osc_stable), .i_int_ref_hz(INT_HZ), .i_ext_ref_hz(EXT_HZ),
    .o_status(o_status), .o_mode(o_mode), .o_cfg(o_cfg), .o_loop_enable(o_loop_enable),
    .o_int_ref_enable(o_int_ref_enable), .o_ext_ref_enable(o_ext_ref_enable), .o_out_hz(o_out_hz),
    .o_bus_hz(o_bus_hz));
  cgm_osc_model osc (.i_ref_clk(i_ref_clk), .i_enable(o_ext_ref_enable), .o_stable(i_osc_stable));
  initial begin
    i_ref_clk = 1'h0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // ============================================================
  // access tasks; every step ends just after an edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : cyc
  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task automatic test_done();
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // one-cycle strobe, then let the word land
  task automatic wr(input cgm_cfg_type c);
    i_cfg = c;
    i_cfg_write = 1'h1;
    cyc(1);
    i_cfg_write = 1'h0;
    cyc(2);
  endtask : wr
  // fields: select, ref divider, ref source, low power, crystal, loop type
  function automatic cgm_cfg_type mk(input logic [1:0] s, input logic [2:0] r, input logic i, l, x, p);
    // internal reference output off, divider never by one before trimming
    return '{s, r, i, 1'h0, 2'h1, l, x, x, p, 4'h4};
  endfunction : mk
  // bounded wait on one status field; a timeout ends the run
  task automatic wt(input string name, input int k, input logic [1:0] v);
    logic [1:0] s;
    for (int n = 0; n < 3000; n++) begin
      s = (k == 0) ? o_status.output_source_status : (k == 1) ? {1'h0, o_status.lock} :
          (k == 2) ? {1'h0, o_status.oscillator_ready} : (k == 3) ? {1'h0, o_status.internal_ref_stable} :
          {1'h0, o_status.loop_type_status};
      if (s === v) break;
      cyc(1);
    end
    chk(name, v, s);
    if (s !== v) test_done();
  endtask : wt
  // ============================================================
  // main sequence
  initial begin
    failures = 0;
    samples_checked = 0;
    i_rst = 1'h1;
    i_cfg_write = 1'h0;
    i_cfg = '0;
    bad = '{mk(2'h0, 3'h2, 1'h0, 1'h0, 1'h0, 1'h1), mk(2'h2, 3'h7, 1'h0, 1'h1, 1'h0, 1'h0),
            mk(2'h3, 3'h0, 1'h1, 1'h0, 1'h0, 1'h0)};
    cyc(5);
    i_rst = 1'h0;
    chk("mode", CGM_FEI, o_mode);
    chk("output_divider", OUTPUT_DIVIDER_RESET, o_cfg.output_divider);
    chk("irefst", 1'h1, o_status.ref_source_status);
    wt("settled", 3, 2'h1);
    wt("lock", 1, 2'h1);
    cyc(3);
    chk("fei_hz", (48'(INT_HZ) << 10) >> 1, o_out_hz);
    chk("bus_hz", (48'(INT_HZ) << 9) >> 1, o_bus_hz);
    foreach (bad[n]) begin
      wr(bad[n]);
      chk("refused", CGM_FEI, o_mode);
    end
    wr(mk(2'h1, 3'h0, 1'h1, 1'h0, 1'h0, 1'h0));
    wt("output_source_status", 0, OUTPUT_SOURCE_SELECT_INT);
    chk("mode", CGM_FBI, o_mode);
    cyc(2);
    chk("fbi_hz", 48'(INT_HZ) >> 1, o_out_hz);
    wr(mk(2'h1, 3'h0, 1'h1, 1'h1, 1'h0, 1'h0));
    chk("mode", CGM_LOWPOWER_BYPASS_INTERNAL_MODE, o_mode);
    chk("loop_en", 1'h0, o_loop_enable);
    wr(mk(2'h2, 3'h7, 1'h0, 1'h0, 1'h1, 1'h0));
    chk("output_source_status_hold", OUTPUT_SOURCE_SELECT_INT, o_status.output_source_status);
    wt("osc_ready", 2, 2'h1);
    wt("output_source_status", 0, OUTPUT_SOURCE_SELECT_EXT);
    chk("irefst", 1'h0, o_status.ref_source_status);
    chk("mode", CGM_FBE, o_mode);
    cyc(2);
    wt("lock", 1, 2'h1);
    chk("fbe_hz", 48'(EXT_HZ) >> 1, o_out_hz);
    wr(mk(2'h2, 3'h2, 1'h0, 1'h0, 1'h1, 1'h1));
    wt("loop_type_status", 4, 2'h1);
    cyc(2);
    wt("lock", 1, 2'h1);
    wr(mk(2'h0, 3'h2, 1'h0, 1'h0, 1'h1, 1'h1));
    wt("output_source_status", 0, OUTPUT_SOURCE_SELECT_SYN);
    chk("mode", CGM_PEE, o_mode);
    cyc(2);
    chk("pee_hz", ((48'(EXT_HZ) >> 2) * 48'h10) >> 1, o_out_hz);
    wr(mk(2'h0, 3'h7, 1'h0, 1'h0, 1'h1, 1'h0));
    wt("loop_type_status", 4, 2'h0);
    cyc(2);
    wt("lock", 1, 2'h1);
    wt("output_source_status", 0, OUTPUT_SOURCE_SELECT_LOOP);
    chk("mode", CGM_FEE, o_mode);
    cyc(2);
    chk("fee_hz", ((48'(EXT_HZ) >> 7) << 10) >> 1, o_out_hz);
    chk("irc_en", 1'h0, o_int_ref_enable);
    i_rst = 1'h1;
    cyc(1);
    i_rst = 1'h0;
    cyc(1);
    chk("mode", CGM_FEI, o_mode);
    chk("output_divider", OUTPUT_DIVIDER_RESET, o_cfg.output_divider);
    test_done();
  end
endmodule : cgm_mode_ctrl_tb
